// file: rtl/rcc_top.sv
/*
 * rcc_top: per-channel series-resistance cancellation register, diode fault
 * reporting, fault-skipping round-robin sequencer and serial target port.
 * Assumes open-drain serial pins resolved outside; fault detector levels async.
 */
// What this block does
// - cancellation on for a remote conversion whose channel bit is 1 when it starts; ch7 is bit 6
// - channels 1 to 6 sit in bits 0 to 5, channel 1 in the LSB
// - open or shorted sense inputs show as a diode fault in status
// - sequencer skips every remote channel flagged with a diode fault
// - answer only target address 1001101; bit 0 of address byte is direction
// - cancellation lengthens a remote conversion by 125 ms
`timescale 1ns/100ps
`default_nettype none
module rcc_top
	import rcc_pkg::*;
#(
	parameter int unsigned CANCEL_EXTRA_CYC = RCC_CANCEL_EXTRA_CYC,
	parameter int unsigned BASE_CONV_CYC = RCC_BASE_CONV_CYC
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic CLK_EN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic [6:0] DIODE_FAULT_DET,
	output logic [6:0] DIODE_FAULT,
	output logic [6:0] CANCEL_EN,
	output logic CONV_START,
	output logic [2:0] CONV_CHANNEL,
	output logic CONV_CANCEL
);
	// ==========================================================
	// input synchronisers
	logic scl_s, sda_s;
	logic [6:0] fault;

	rcc_sync3 #(.W(2), .INIT(2'h3)) u_sync_bus (
		.clk(CORE_CLK),
		.rst(RST),
		.ce(CLK_EN),
		.d_in({SCL_IN, SDA_IN}),
		.q_out({scl_s, sda_s})
	);

	rcc_sync3 #(.W(7), .INIT(7'h00)) u_sync_fault (
		.clk(CORE_CLK),
		.rst(RST),
		.ce(CLK_EN),
		.d_in(DIODE_FAULT_DET),
		.q_out(fault)
	);

	// ==========================================================
	// serial target and registers
	rcc_phase_t phase_q, phase_d;
	logic [3:0] cnt_q, cnt_d;
	logic ack_q, ack_d, mack_q, mack_d, rw_q, rw_d, oe_q, oe_d;
	logic [7:0] shift_q, shift_d, ptr_q, ptr_d, tx_q, tx_d, rd_byte;
	logic [6:0] cancel_q, cancel_d;
	logic scl_p_q, sda_p_q, wr_en, load_tx;
	logic scl_rise, scl_fall, bus_start, bus_stop, rx_phase;

	assign scl_rise = scl_s & ~scl_p_q;
	assign scl_fall = ~scl_s & scl_p_q;
	assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
	assign rx_phase = (phase_q == PH_ADDR) || (phase_q == PH_CMD) || (phase_q == PH_WDATA);

	always_comb begin
		rd_byte = RCC_UNMAPPED_RD;
		if (ptr_q == RCC_OFS_CANCEL) begin
			rd_byte = {1'b0, cancel_q};
		end else if (ptr_q == RCC_OFS_FAULT) begin
			rd_byte = {1'b0, fault};
		end
	end

	always_comb begin
		phase_d = phase_q;
		cnt_d = cnt_q;
		ack_d = ack_q;
		mack_d = mack_q;
		rw_d = rw_q;
		oe_d = oe_q;
		shift_d = shift_q;
		ptr_d = ptr_q;
		tx_d = tx_q;
		wr_en = 1'b0;
		load_tx = 1'b0;
		if (bus_start) begin
			phase_d = PH_ADDR;
			cnt_d = 4'h0;
			ack_d = 1'b0;
			mack_d = 1'b0;
			oe_d = 1'b0;
		end else if (bus_stop) begin
			phase_d = PH_IDLE;
			ack_d = 1'b0;
			mack_d = 1'b0;
			oe_d = 1'b0;
		end else if (scl_rise) begin
			if (rx_phase && !ack_q && cnt_q < 4'h8) begin
				shift_d = {shift_q[6:0], sda_s};
				cnt_d = cnt_q + 4'h1;
			end
			if (mack_q && sda_s) begin
				phase_d = PH_SKIP;
			end
		end else if (scl_fall) begin
			if (ack_q) begin
				ack_d = 1'b0;
				oe_d = 1'b0;
				cnt_d = 4'h0;
				if (phase_q == PH_ADDR) begin
					if (rw_q) begin
						phase_d = PH_READ;
						load_tx = 1'b1;
					end else begin
						phase_d = PH_CMD;
					end
				end else if (phase_q == PH_CMD) begin
					phase_d = PH_WDATA;
				end
			end else if (mack_q) begin
				mack_d = 1'b0;
				load_tx = (phase_q == PH_READ);
			end else if (phase_q == PH_READ) begin
				if (cnt_q == 4'h8) begin
					oe_d = 1'b0;
					mack_d = 1'b1;
				end else begin
					oe_d = ~tx_q[3'(4'h7 - cnt_q)];
					cnt_d = cnt_q + 4'h1;
				end
			end else if (rx_phase && cnt_q == 4'h8) begin
				if (phase_q == PH_ADDR) begin
					if (shift_q[7:1] == RCC_TARGET_ADDR) begin
						ack_d = 1'b1;
						oe_d = 1'b1;
						rw_d = shift_q[0];
					end else begin
						phase_d = PH_SKIP;
					end
				end else begin
					ack_d = 1'b1;
					oe_d = 1'b1;
					if (phase_q == PH_CMD) begin
						ptr_d = shift_q;
					end else begin
						wr_en = 1'b1;
					end
				end
			end
		end
		if (load_tx) begin
			tx_d = rd_byte;
			oe_d = ~rd_byte[7];
			cnt_d = 4'h1;
		end
	end

	always_comb begin
		cancel_d = cancel_q;
		if (wr_en && ptr_q == RCC_OFS_CANCEL) begin
			cancel_d = shift_q[RCC_CANCEL_LSB +: RCC_NCH];
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			phase_q <= PH_IDLE;
			cnt_q <= 4'h0;
			ack_q <= 1'b0;
			mack_q <= 1'b0;
			rw_q <= 1'b0;
			oe_q <= 1'b0;
			shift_q <= 8'h00;
			ptr_q <= RCC_PTR_RST;
			tx_q <= 8'h00;
			cancel_q <= RCC_CANCEL_RST;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else if (CLK_EN) begin
			phase_q <= phase_d;
			cnt_q <= cnt_d;
			ack_q <= ack_d;
			mack_q <= mack_d;
			rw_q <= rw_d;
			oe_q <= oe_d;
			shift_q <= shift_d;
			ptr_q <= ptr_d;
			tx_q <= tx_d;
			cancel_q <= cancel_d;
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// ==========================================================
	// round-robin sequencer, channel 0 is local
	logic [2:0] ch_q, ch_d, nxt, c;
	logic [RCC_TMR_W-1:0] tmr_q, tmr_d;
	logic start_q, start_d, cact_q, cact_d, found, cur_faulted, nxt_cancel;

	assign cur_faulted = (ch_q != 3'h0) && fault[3'(ch_q - 3'h1)];

	always_comb begin
		nxt = 3'h0;
		found = 1'b0;
		c = 3'h0;
		for (int i = 1; i <= 8; i++) begin
			c = 3'(ch_q + 3'(i));
			if (!found && (c == 3'h0 || !fault[3'(c - 3'h1)])) begin
				nxt = c;
				found = 1'b1;
			end
		end
		nxt_cancel = (nxt != 3'h0) && cancel_q[3'(nxt - 3'h1)];
		ch_d = ch_q;
		start_d = 1'b0;
		cact_d = cact_q;
		tmr_d = tmr_q - 24'h000001;
		if (tmr_q == 24'h000000 || cur_faulted) begin
			ch_d = nxt;
			start_d = 1'b1;
			cact_d = nxt_cancel;
			tmr_d = nxt_cancel ? RCC_TMR_W'(BASE_CONV_CYC + CANCEL_EXTRA_CYC - 1)
				: RCC_TMR_W'(BASE_CONV_CYC - 1);
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ch_q <= 3'h0;
			tmr_q <= 24'h000000;
			start_q <= 1'b0;
			cact_q <= 1'b0;
		end else if (CLK_EN) begin
			ch_q <= ch_d;
			tmr_q <= tmr_d;
			start_q <= start_d;
			cact_q <= cact_d;
		end
	end

	assign SDA_OUT = 1'b0 & oe_q;
	assign SDA_OE = oe_q;
	assign DIODE_FAULT = fault;
	assign CANCEL_EN = cancel_q;
	assign CONV_START = start_q;
	assign CONV_CHANNEL = ch_q;
	assign CONV_CANCEL = cact_q;

	// ==========================================================
	// checks
	default clocking cb @(posedge CORE_CLK iff CLK_EN); endclocking
	default disable iff (RST);

	a_cancel_follow: assert property (start_d
		|=> cact_q == (ch_q != 3'h0 && $past(cancel_q[3'(ch_d - 3'h1)])))
		else $error("cancel flag does not match channel enable bit");
	a_cancel_write: assert property (wr_en && ptr_q == RCC_OFS_CANCEL
		|=> cancel_q == $past(shift_q[6:0]))
		else $error("cancel register bits misplaced");
	a_bit7_reads0: assert property (load_tx && ptr_q == RCC_OFS_CANCEL |=> !tx_q[7])
		else $error("unused bit 7 read as one");
	a_fault_read: assert property (load_tx && ptr_q == RCC_OFS_FAULT
		|=> tx_q[6:0] == $past(fault))
		else $error("fault status read wrong");
	a_skip_faulted: assert property (start_d && nxt != 3'h0 |-> !fault[3'(nxt - 3'h1)])
		else $error("faulted channel started");
	a_abort_faulted: assert property (cur_faulted |=> start_q)
		else $error("faulted channel not abandoned");
	a_addr_reject: assert property (scl_fall && !bus_start && !bus_stop && !ack_q && !mack_q
		&& phase_q == PH_ADDR && cnt_q == 4'h8 && shift_q[7:1] != RCC_TARGET_ADDR
		|=> !oe_q && phase_q == PH_SKIP)
		else $error("foreign address acknowledged");
	a_ext_time: assert property (start_q && cact_q
		|-> tmr_q == RCC_TMR_W'(BASE_CONV_CYC + CANCEL_EXTRA_CYC - 1))
		else $error("cancel conversion length wrong");
	a_base_time: assert property (start_q && !cact_q
		|-> tmr_q == RCC_TMR_W'(BASE_CONV_CYC - 1))
		else $error("plain conversion length wrong");
	c_cancel_write: cover property (wr_en && ptr_q == RCC_OFS_CANCEL);
	c_read_byte: cover property (load_tx && phase_q == PH_READ);
	c_cancel_conv: cover property (start_q && cact_q);
	c_skip: cover property (start_d && nxt != 3'(ch_q + 3'h1));
endmodule
`default_nettype wire

// file: rtl/rcc_pkg.sv
/*
 * rcc_pkg: constants and types of the remote-channel cancellation block:
 * serial target address, register offsets, reset values and timing counts.
 * Assumes a 10 MHz core clock.
 */
package rcc_pkg;

	// ==========================================================
	// serial target
	localparam logic [6:0] RCC_TARGET_ADDR = 7'h4D;

	// ==========================================================
	// register map
	localparam logic [7:0] RCC_OFS_CANCEL = 8'h4A;
	localparam logic [7:0] RCC_OFS_FAULT = 8'h4F;
	localparam logic [7:0] RCC_UNMAPPED_RD = 8'h00;
	localparam int RCC_NCH = 7;
	localparam int RCC_CANCEL_LSB = 0;
	localparam int RCC_UNUSED_BIT = 7;
	localparam logic [6:0] RCC_CANCEL_RST = 7'h00;
	localparam logic [7:0] RCC_PTR_RST = 8'h00;

	// ==========================================================
	// timing
	localparam int unsigned RCC_CLK_HZ = 10000000;
	localparam int unsigned RCC_CANCEL_EXTRA_MS = 125;
	localparam int unsigned RCC_CANCEL_EXTRA_CYC = RCC_CANCEL_EXTRA_MS * (RCC_CLK_HZ / 1000);
	localparam int unsigned RCC_BASE_CONV_CYC = 1000;
	localparam int RCC_TMR_W = 24;

	typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_CMD, PH_WDATA, PH_READ, PH_SKIP} rcc_phase_t;

endpackage

// file: rtl/rcc_sync3.sv
/*
 * rcc_sync3: three-flop synchroniser with agreement filter for W bits.
 * Assumes inputs asynchronous to clk; output changes once stages 2 and 3 agree.
 */
`timescale 1ns/100ps
`default_nettype none
module rcc_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] s1_q, s2_q, s3_q, out_q, out_d;

	always_comb begin
		out_d = out_q;
		for (int i = 0; i < W; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				out_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			out_q <= INIT;
		end else if (ce) begin
			s1_q <= d_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			out_q <= out_d;
		end
	end

	assign q_out = out_q;
endmodule
`default_nettype wire

// file: dv/rcc_host_model.sv
/*
 * rcc_host_model: serial host controller driving the target port.
 * Assumes a pull-up on the data line, an 8-cycle half bit, and the core clock as pacing.
 */
`timescale 1ns/100ps
`default_nettype none
module rcc_host_model
	import rcc_pkg::*;
(
	input wire logic clk,
	input wire logic sda_oe,
	output logic scl,
	output logic sda_in
);
	logic sda_m;
	logic [7:0] rd;
	event got;
	// ==========================================================
	// wired-and data line with pull-up
	assign sda_in = sda_m & ~sda_oe;
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic hp;
		repeat (8) @(negedge clk);
	endtask
	task automatic start;
		sda_m = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		sda_m = 1'b0;
		hp();
		scl = 1'b0;
	endtask
	task automatic stop;
		sda_m = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		sda_m = 1'b1;
		hp();
	endtask
	task automatic xbyte(input logic [7:0] d, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= -1; i--) begin
			sda_m = (i < 0) ? 1'b1 : d[i];
			hp();
			scl = 1'b1;
			hp();
			if (i < 0) begin
				ack = sda_in;
			end else begin
				r[i] = sda_in;
			end
			scl = 1'b0;
		end
	endtask
	// ==========================================================
	// write byte: ack is 0 only if all three bytes were acked
	task automatic wr(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] v,
			output logic ack);
		logic [7:0] r;
		logic a0;
		logic a1;
		logic a2;
		start();
		xbyte({a, 1'b0}, r, a0);
		xbyte(ofs, r, a1);
		xbyte(v, r, a2);
		stop();
		ack = a0 | a1 | a2;
	endtask
	task automatic rd_reg(input logic [7:0] ofs, output logic ack);
		logic [7:0] r;
		logic a0;
		logic a1;
		logic nk;
		start();
		xbyte({RCC_TARGET_ADDR, 1'b0}, r, a0);
		xbyte(ofs, r, a1);
		start();
		xbyte({RCC_TARGET_ADDR, 1'b1}, r, ack);
		xbyte(8'hFF, rd, nk);
		stop();
		ack = ack | a0 | a1;
		->got;
	endtask
endmodule
`default_nettype wire

// file: dv/rcc_top_tb.sv
/*
 * rcc_top_tb: self-checking bench for the cancellation block.
 * Assumes rcc_host_model on the serial pins and shortened conversion counts.
 */
`timescale 1ns/100ps
`default_nettype none
module rcc_top_tb;
	import rcc_pkg::*;
	localparam int BASE = 10;
	localparam int EXTRA = 20;
	// alarm mask offsets sit outside this block; values arbitrary
	localparam logic [7:0] MASK_ALERT_OFS = 8'h00;
	localparam logic [7:0] MASK_OVERTEMP_OFS = 8'h01;
	logic CORE_CLK;
	logic RST;
	logic CLK_EN;
	logic [6:0] det;
	wire logic scl;
	wire logic sda;
	wire logic oe;
	wire logic sdo;
	wire logic [6:0] flt;
	wire logic [6:0] cen;
	wire logic cst;
	wire logic [2:0] cch;
	wire logic ccan;
	int n_errors = 0;
	int compares = 0;
	logic [7:0] q[$];
	rcc_top #(.CANCEL_EXTRA_CYC(EXTRA), .BASE_CONV_CYC(BASE)) dut (.CORE_CLK(CORE_CLK),
		.RST(RST), .CLK_EN(CLK_EN), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sdo), .SDA_OE(oe),
		.DIODE_FAULT_DET(det), .DIODE_FAULT(flt), .CANCEL_EN(cen), .CONV_START(cst),
		.CONV_CHANNEL(cch), .CONV_CANCEL(ccan));
	rcc_host_model h (.clk(CORE_CLK), .sda_oe(oe), .scl(scl), .sda_in(sda));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("errors=%0d compares=%0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		CORE_CLK = 1'b0;
		forever #50 CORE_CLK = ~CORE_CLK;
	end
	// ==========================================================
	// read results against the oldest note
	always @(h.got) chk(h.rd, q.pop_front());
	// ==========================================================
	// sequencer order, length and cancel flag
	logic [2:0] pch;
	logic [2:0] e;
	logic pcan;
	logic have;
	logic [6:0] fp;
	logic [6:0] cp;
	int cnt;
	logic en_p;
	// enable seen by the edge that made the current outputs
	always @(posedge CORE_CLK) en_p <= CLK_EN;
	always @(negedge CORE_CLK) begin
		if (RST) begin
			have = 1'b0;
		end else if (en_p && cst) begin
			if (have && !(pch != 3'h0 && fp[pch-1])) chk(8'(cnt), pcan ? EXTRA + BASE : BASE);
			e = pch;
			do e = e + 3'h1; while (e != 3'h0 && fp[e-1]);
			if (have) chk({5'h0, cch}, {5'h0, e});
			chk({7'h0, ccan}, {7'h0, cch != 3'h0 && cp[cch-1]});
			pch = cch;
			pcan = ccan;
			cnt = 1;
			have = 1'b1;
		end else if (en_p) begin
			cnt++;
		end
		fp = flt;
		cp = cen;
	end
	// ==========================================================
	// main sequence
	initial begin
		logic ack;
		logic [7:0] v;
		logic [6:0] a;
		logic [7:0] frz;
		int s;
		RST = 1'b1;
		CLK_EN = 1'b1;
		det = 7'h00;
		s = $urandom(32'hA40E74DB);
		repeat (5) @(negedge CORE_CLK);
		RST = 1'b0;
		repeat (10) @(negedge CORE_CLK);
		chk({1'b0, cen}, 8'h00);
		q.push_back(8'h00);
		h.rd_reg(RCC_OFS_CANCEL, ack);
		chk({7'h0, ack}, 8'h00);
		for (int i = 0; i < 6; i++) begin
			v = 8'($urandom());
			a = 7'($urandom());
			if (a == RCC_TARGET_ADDR) a = a ^ 7'h01;
			h.wr(a, RCC_OFS_CANCEL, ~v, ack);
			chk({7'h0, ack}, 8'h01);
			h.wr(RCC_TARGET_ADDR, RCC_OFS_CANCEL, v, ack);
			chk({7'h0, ack}, 8'h00);
			chk({1'b0, cen}, {1'b0, v[6:0]});
			q.push_back({1'b0, v[6:0]});
			h.rd_reg(RCC_OFS_CANCEL, ack);
			repeat (60) @(negedge CORE_CLK);
		end
		h.wr(RCC_TARGET_ADDR, 8'h4B, ~v, ack);
		chk({7'h0, ack}, 8'h00);
		chk({1'b0, cen}, {1'b0, v[6:0]});
		for (int k = 0; k < 4; k++) begin
			det = (k == 3) ? 7'h7F : 7'($urandom());
			repeat (10) @(negedge CORE_CLK);
			chk({1'b0, flt}, {1'b0, det});
			h.wr(RCC_TARGET_ADDR, MASK_ALERT_OFS, {1'b0, det}, ack);
			chk({7'h0, ack}, 8'h00);
			h.wr(RCC_TARGET_ADDR, MASK_OVERTEMP_OFS, {1'b0, det}, ack);
			chk({1'b0, cen}, {1'b0, v[6:0]});
			q.push_back({1'b0, det});
			h.rd_reg(RCC_OFS_FAULT, ack);
			repeat (200) @(negedge CORE_CLK);
		end
		det = 7'h00;
		repeat (300) @(negedge CORE_CLK);
		chk({7'h0, sdo}, 8'h00);
		// ==========================================================
		// clock enable low freezes sequencer and fault filter
		CLK_EN = 1'b0;
		frz = {cst, ccan, 3'h0, cch};
		det = 7'h55;
		repeat (20) @(negedge CORE_CLK);
		chk({cst, ccan, 3'h0, cch}, frz);
		chk({1'b0, flt}, 8'h00);
		det = 7'h00;
		CLK_EN = 1'b1;
		repeat (50) @(negedge CORE_CLK);
		wrap_up();
	end
	initial begin
		repeat (60000) @(posedge CORE_CLK);
		n_errors++;
		wrap_up();
	end
endmodule
`default_nettype wire
